//--- src/xp_pkg.sv
// Purpose: shared constants and types of the crosspoint serial configuration port
// Assumes: 8 outputs, 16 inputs, AXI4-Lite register access with 32-bit data
// Notes: one route entry is 5 bits, disable flag above the 4-bit input index
package xp_pkg;
    // geometry of the switch and of the serial formats
    localparam int XP_OUTS = 8;
    localparam int XP_FRAME_BITS = 40;
    localparam int XP_WORD_BITS = 8;
    localparam int XP_CNT_W = 7;
    localparam logic [XP_CNT_W-1:0] XP_CNT_MAX = 7'h7F;
    localparam logic [XP_CNT_W-1:0] XP_FRAME_CNT = 7'h28;
    localparam logic [XP_CNT_W-1:0] XP_WORD_CNT = 7'h08;
    // addressed word field positions, first bit in bit 0
    localparam int XP_AW_OUT_LSB = 0;
    localparam int XP_AW_IDX_LSB = 3;
    localparam int XP_AW_OFF_BIT = 7;

    // one output's setting: off=1 is high impedance
    typedef struct packed {
        logic off;
        logic [3:0] idx;
    } xp_route_t;
    typedef xp_route_t [XP_OUTS-1:0] xp_map_t;

    localparam xp_route_t XP_ROUTE_RESET = 5'h10;
    localparam xp_route_t XP_ROUTE_BCAST = 5'h00;

    // serial pins, sampled together
    typedef struct packed {
        logic sclk;
        logic sdin;
        logic cs_n;
        logic cfg;
        logic mode;
        logic rst;
        logic bcast;
    } xp_pins_t;
    localparam xp_pins_t XP_PINS_IDLE = 7'h10; // select high, all other pins low

    // register map, byte addresses
    localparam int XP_ADDR_W = 12;
    localparam logic [11:0] XP_REG_CTRL = 12'h000;
    localparam logic [11:0] XP_REG_STATUS = 12'h004;
    localparam logic [11:0] XP_REG_ACT_LO = 12'h008;
    localparam logic [11:0] XP_REG_ACT_HI = 12'h00C;
    localparam logic [11:0] XP_REG_PEND_LO = 12'h010;
    localparam logic [11:0] XP_REG_PEND_HI = 12'h014;
    localparam logic [31:0] XP_CTRL_RESET = 32'h00000000;
    localparam int XP_CTRL_SRST_BIT = 0;
    localparam int XP_CTRL_SBCAST_BIT = 1;
    localparam int XP_ST_NEW_BIT = 0;
    localparam int XP_ST_MODE_BIT = 1;
    localparam int XP_ST_ARM_BIT = 2;
    localparam int XP_ST_CNT_LSB = 8;
    localparam logic [1:0] XP_RESP_OKAY = 2'h0;
    localparam logic [1:0] XP_RESP_SLVERR = 2'h2;
endpackage : xp_pkg

//--- src/xp_serial_port.sv
// Purpose: serial configuration port of a 16x8 crosspoint, with AXI4-Lite status access
// Assumes: all serial pins are asynchronous to aclk and slower than aclk/4
// Notes: serial clock edges are found by oversampling after a two-stage synchroniser
//
// Functional notes
// - full frame is 40 bits; output n uses bits 5n..5n+4, index LSB first, then off.
// - mode high selects the 8-bit addressed word format.
// - addressed word updates only the named output's pending setting.
// - word bits 0-2 output, 3-6 input index, bit 7 off flag.
// - serial data out cascades only in full-frame mode.
// - load register shifts; oldest bit appears on serial data out.
// - one configure pulse applies pending settings of all chained devices together.
// - reset high forces every output to input 0, disabled.
// - broadcast high, with reset low, forces every output enabled on input 0; reset wins when both are high.
// - reset and broadcast act on level, independent of the serial port.
// - reset or broadcast overwrite stored configuration contents.
// - serial data is sampled only on falling serial clock edges.
// - configure pulse applies new data only; repeat pulse without new data does nothing.
// - select high makes the device ignore serial data and clock.
// - mode low selects the 40-bit full-frame format.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
module xp_serial_port
    import xp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [XP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [XP_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sclk,
    input wire logic sdin,
    input wire logic cs_n,
    input wire logic cfg,
    input wire logic mode,
    input wire logic rst,
    input wire logic all_to_input_zero,
    output logic sdout,
    output xp_map_t route
);
    // word-aligned register decode, shared by read and write paths
    function automatic logic xp_mapped(input logic [XP_ADDR_W-1:0] a);
        logic [11:0] w;
        w = {a[11:2], 2'b00};
        xp_mapped = (w == XP_REG_CTRL) || (w == XP_REG_STATUS) || (w == XP_REG_ACT_LO) ||
                    (w == XP_REG_ACT_HI) || (w == XP_REG_PEND_LO) || (w == XP_REG_PEND_HI);
    endfunction : xp_mapped

    xp_pins_t pins_raw;
    xp_pins_t meta_ff;
    xp_pins_t sync_ff;
    xp_pins_t prev_ff;
    logic sclk_rise, sclk_fall, cs_rise, cfg_rise, force_rst, force_bc;
    logic armed_ff, nxt_armed, new_ff, nxt_new, sdout_ff, nxt_sdout;
    logic commit_full, commit_addr;
    logic [XP_CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [XP_FRAME_BITS-1:0] sr_ff, nxt_sr;
    logic [XP_WORD_BITS-1:0] aw_ff, nxt_aw;
    xp_map_t pend_ff, nxt_pend, act_ff, nxt_act;
    logic [31:0] ctrl_ff, nxt_ctrl, rdata_ff, nxt_rdata;
    logic [XP_ADDR_W-1:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [39:0] act_flat, pend_flat;
    logic [31:0] status_word;

    assign pins_raw = '{sclk: sclk, sdin: sdin, cs_n: cs_n, cfg: cfg, mode: mode,
                        rst: rst, bcast: all_to_input_zero};

    // two-stage synchroniser, then one more stage for edge finding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= XP_PINS_IDLE;
            sync_ff <= XP_PINS_IDLE;
            prev_ff <= XP_PINS_IDLE;
        end else begin
            meta_ff <= pins_raw;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // edges seen on the synchronised pins; forcing levels from those pins or the control register
    assign sclk_rise = sync_ff.sclk & ~prev_ff.sclk;
    assign sclk_fall = ~sync_ff.sclk & prev_ff.sclk;
    assign cs_rise = sync_ff.cs_n & ~prev_ff.cs_n;
    assign cfg_rise = sync_ff.cfg & ~prev_ff.cfg;
    assign force_rst = sync_ff.rst | ctrl_ff[XP_CTRL_SRST_BIT];
    assign force_bc = sync_ff.bcast | ctrl_ff[XP_CTRL_SBCAST_BIT];
    // a transfer ends with select rising after enough bits; short ones are dropped
    assign commit_full = cs_rise & armed_ff & ~sync_ff.mode & (cnt_ff >= XP_FRAME_CNT);
    assign commit_addr = cs_rise & armed_ff & sync_ff.mode & (cnt_ff >= XP_WORD_CNT);

    // serial shifting, pending and active settings
    always_comb begin
        nxt_armed = armed_ff;
        nxt_cnt = cnt_ff;
        nxt_sr = sr_ff;
        nxt_aw = aw_ff;
        nxt_pend = pend_ff;
        nxt_act = act_ff;
        nxt_new = new_ff;
        if (sync_ff.cs_n) begin
            nxt_armed = 1'b0;
            nxt_cnt = '0;
        end else if (sclk_rise) begin
            nxt_armed = 1'b1;
        end else if (sclk_fall && armed_ff) begin
            nxt_sr = {sync_ff.sdin, sr_ff[XP_FRAME_BITS-1:1]};
            nxt_aw = {sync_ff.sdin, aw_ff[XP_WORD_BITS-1:1]};
            if (cnt_ff != XP_CNT_MAX) begin
                nxt_cnt = cnt_ff + 7'h01;
            end
        end
        // configure applies only fresh data; set below wins over this clear
        if (cfg_rise && new_ff) begin
            nxt_act = pend_ff;
            nxt_new = 1'b0;
        end
        if (commit_full) begin
            nxt_pend = xp_map_t'(sr_ff);
            nxt_new = 1'b1;
        end else if (commit_addr) begin
            nxt_pend[aw_ff[XP_AW_OUT_LSB+:3]] = '{off: aw_ff[XP_AW_OFF_BIT],
                                                  idx: aw_ff[XP_AW_IDX_LSB+:4]};
            nxt_new = 1'b1;
        end
        // level overrides, independent of the serial state
        if (force_rst) begin
            nxt_pend = {XP_OUTS{XP_ROUTE_RESET}};
            nxt_act = {XP_OUTS{XP_ROUTE_RESET}};
            nxt_new = 1'b0;
        end else if (force_bc) begin
            nxt_pend = {XP_OUTS{XP_ROUTE_BCAST}};
            nxt_act = {XP_OUTS{XP_ROUTE_BCAST}};
            nxt_new = 1'b0;
        end
        // cascade output only in full-frame mode
        nxt_sdout = sync_ff.mode ? 1'b0 : nxt_sr[0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed_ff <= 1'b0;
            cnt_ff <= '0;
            sr_ff <= '0;
            aw_ff <= '0;
            pend_ff <= {XP_OUTS{XP_ROUTE_RESET}};
            act_ff <= {XP_OUTS{XP_ROUTE_RESET}};
            new_ff <= 1'b0;
            sdout_ff <= 1'b0;
        end else begin
            armed_ff <= nxt_armed;
            cnt_ff <= nxt_cnt;
            sr_ff <= nxt_sr;
            aw_ff <= nxt_aw;
            pend_ff <= nxt_pend;
            act_ff <= nxt_act;
            new_ff <= nxt_new;
            sdout_ff <= nxt_sdout;
        end
    end

    assign sdout = sdout_ff;
    assign route = act_ff;
    assign act_flat = act_ff;
    assign pend_flat = pend_ff;
    assign status_word = {17'h00000, cnt_ff, 5'h00, armed_ff, sync_ff.mode, new_ff};

    // handshakes: one write and one read in flight
    assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
    assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    // register slave: address and data in either order, response after both
    always_comb begin
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_ctrl = ctrl_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_awaddr = s_axi_awaddr;
            nxt_aw_got = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
            nxt_w_got = 1'b1;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (aw_got_ff && w_got_ff) begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = xp_mapped(awaddr_ff) ? XP_RESP_OKAY : XP_RESP_SLVERR;
            if ({awaddr_ff[11:2], 2'b00} == XP_REG_CTRL && wstrb_ff[0]) begin
                nxt_ctrl = {24'h000000, 6'h00, wdata_ff[1:0]}; // soft reset, soft broadcast
            end
        end
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = xp_mapped(s_axi_araddr) ? XP_RESP_OKAY : XP_RESP_SLVERR;
            case ({s_axi_araddr[11:2], 2'b00})
                XP_REG_CTRL: begin
                    nxt_rdata = ctrl_ff;
                end
                XP_REG_STATUS: begin
                    nxt_rdata = status_word;
                end
                XP_REG_ACT_LO: begin
                    nxt_rdata = act_flat[31:0];
                end
                XP_REG_ACT_HI: begin
                    nxt_rdata = {24'h000000, act_flat[39:32]};
                end
                XP_REG_PEND_LO: begin
                    nxt_rdata = pend_flat[31:0];
                end
                XP_REG_PEND_HI: begin
                    nxt_rdata = {24'h000000, pend_flat[39:32]};
                end
                default: begin
                    nxt_rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_ff <= '0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= XP_RESP_OKAY;
            ctrl_ff <= XP_CTRL_RESET;
            rvalid_ff <= 1'b0;
            rresp_ff <= XP_RESP_OKAY;
            rdata_ff <= 32'h00000000;
        end else begin
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            ctrl_ff <= nxt_ctrl;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
        end
    end

    // checks on the serial port behaviour
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_quiet;
        !force_rst && !force_bc;
    endsequence
    sequence s_end_full;
        commit_full ##0 s_quiet;
    endsequence
    sequence s_end_addr;
        commit_addr ##0 s_quiet;
    endsequence

    a_sdout_addr_quiet: assert property (sync_ff.mode |=> !sdout)
        else $error("serial out active in addressed mode");
    a_reset_forces_off: assert property (force_rst |=> route == {XP_OUTS{XP_ROUTE_RESET}})
        else $error("reset did not disable all outputs");
    a_bcast_forces_zero: assert property (!force_rst && force_bc |=>
        route == {XP_OUTS{XP_ROUTE_BCAST}} && pend_ff == {XP_OUTS{XP_ROUTE_BCAST}})
        else $error("broadcast did not connect all outputs to input zero");
    a_select_high_ignore: assert property (sync_ff.cs_n |=> $stable(sr_ff))
        else $error("shift register moved while select high");
    a_shift_on_fall: assert property (armed_ff && !sync_ff.cs_n && sclk_fall |=>
        sr_ff[XP_FRAME_BITS-1] == $past(sync_ff.sdin) && sr_ff[38:0] == $past(sr_ff[39:1]))
        else $error("falling edge did not shift in data");
    a_no_shift_on_rise: assert property (sclk_rise |=> $stable(sr_ff))
        else $error("rising edge shifted data");
    a_cfg_applies_new: assert property (cfg_rise && new_ff ##0 s_quiet |=>
        route == $past(pend_ff))
        else $error("configure did not apply pending settings");
    a_cfg_repeat_none: assert property (cfg_rise && !new_ff ##0 s_quiet |=>
        $stable(route))
        else $error("repeat configure changed outputs");
    a_full_frame_load: assert property (s_end_full |=> pend_ff == $past(sr_ff) ##1
        new_ff || $past(cfg_rise) || $past(force_rst) || $past(force_bc))
        else $error("full frame not loaded into pending settings");
    a_addr_one_output: assert property (s_end_addr |=>
        pend_ff[$past(aw_ff[2:0])] == {$past(aw_ff[7]), $past(aw_ff[6:3])} &&
        ($past(aw_ff[2:0]) == 3'h0 || pend_ff[0] == $past(pend_ff[0])) && new_ff)
        else $error("addressed word did not update its output");
endmodule : xp_serial_port

//--- testbench/xp_ctrl_model.sv
// Purpose: controller model that drives the serial programming pins
// Assumes: serial clock of 64 ns made from aclk, stands low outside frames but for one pulse after select rises
// Notes: records serial data out before each falling clock for chain checks
module xp_ctrl_model
    import xp_pkg::*;
(
    input wire logic aclk,
    input wire logic sdout,
    output logic sclk,
    output logic sdin,
    output logic cs_n,
    output logic cfg
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [79:0] cap;

    // idle pin levels at time zero
    initial begin
        sclk = 1'b0;
        sdin = 1'b0;
        cs_n = 1'b1;
        cfg = 1'b0;
        cap = '0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge aclk);
    endtask : hold

    // one transfer of n bits, bit 0 first; sel low keeps the port deselected
    task automatic xfer(input logic [79:0] d, input int n, input logic sel);
        int k;
        @(posedge aclk);
        cs_n <= !sel;
        hold(4);
        for (k = 0; k < n; k++) begin
            sdin <= d[k];
            sclk <= 1'b1;
            hold(3);
            @(negedge aclk);
            cap[k] = sdout;
            @(posedge aclk);
            sclk <= 1'b0;
            hold(4);
        end
        cs_n <= 1'b1;
        sdin <= !d[n-1]; // data line no longer holds its last value
        hold(4);
        sclk <= 1'b1;
        hold(4);
        sclk <= 1'b0;
        hold(4);
    endtask : xfer

    // configure strobe, only after every bit is in
    task automatic cfg_pulse();
        @(posedge aclk);
        cfg <= 1'b1;
        hold(4);
        cfg <= 1'b0;
        hold(6);
    endtask : cfg_pulse
endmodule : xp_ctrl_model

//--- testbench/xp_serial_port_tb.sv
// Purpose: self-checking bench of the crosspoint serial configuration port
// Assumes: serial pins come from the controller model, registers over AXI4-Lite
// Notes: bench drives mode and both override pins itself
module xp_serial_port_tb
    import xp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [39:0] F1 = 40'hA53C961E87;
    localparam logic [39:0] F2 = 40'h5AC369E178;
    localparam xp_map_t M_RST = {8{XP_ROUTE_RESET}};
    localparam xp_map_t M_BC = {8{XP_ROUTE_BCAST}};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic mode = 1'b0, rst = 1'b0, bcast = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sclk, sdin, cs_n, cfg, sdout;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    xp_map_t route, expm;
    int error_cnt = 0;
    int checked = 0;

    // clock, 125 MHz
    always #4 aclk = ~aclk;

    xp_serial_port xp_serial_port_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sclk(sclk), .sdin(sdin),
        .cs_n(cs_n), .cfg(cfg), .mode(mode), .rst(rst), .all_to_input_zero(bcast),
        .sdout(sdout), .route(route));

    xp_ctrl_model xp_ctrl_model_inst (.aclk(aclk), .sdout(sdout), .sclk(sclk),
        .sdin(sdin), .cs_n(cs_n), .cfg(cfg));

    task automatic final_report();
        if (error_cnt == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_resp

    // samples route away from the clock edge, then returns on a rising edge
    task automatic chk_map(input logic [39:0] exp);
        @(negedge aclk);
        checked++;
        if (route !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, route, exp);
        end
        @(posedge aclk);
    endtask : chk_map

    // write with address and data offered together
    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            ta = ta | (awready === 1'b1);
            tw = tw | (wready === 1'b1);
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        chk_resp(bresp, er);
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr_chk

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        chk_word(rdata, ed);
        chk_resp(rresp, er);
        @(posedge aclk);
        rready <= 1'b0;
    endtask : rd_chk

    // reset values and an unmapped address
    task automatic t_reset();
        chk_map(M_RST);
        rd_chk(XP_REG_CTRL, XP_CTRL_RESET, XP_RESP_OKAY);
        rd_chk(XP_REG_ACT_HI, {24'h0, XP_ROUTE_RESET, XP_ROUTE_RESET[4:2]}, XP_RESP_OKAY);
        rd_chk(12'h018, 32'h00000000, XP_RESP_SLVERR);
        wr_chk(12'h018, 32'h00000003, XP_RESP_SLVERR);
        chk_map(M_RST);
    endtask : t_reset

    // full frame, short frame and deselected clocking
    task automatic t_frame();
        mode <= 1'b0;
        xp_ctrl_model_inst.xfer({40'h0, F1}, 40, 1'b1);
        chk_map(M_RST);
        xp_ctrl_model_inst.cfg_pulse();
        chk_map(F1);
        rd_chk(XP_REG_PEND_LO, F1[31:0], XP_RESP_OKAY);
        rd_chk(XP_REG_ACT_HI, {24'h0, F1[39:32]}, XP_RESP_OKAY);
        xp_ctrl_model_inst.xfer({40'h0, F2}, 20, 1'b1);
        xp_ctrl_model_inst.cfg_pulse();
        chk_map(F1);
        xp_ctrl_model_inst.xfer({40'h0, F2}, 40, 1'b0);
        xp_ctrl_model_inst.cfg_pulse();
        chk_map(F1);
    endtask : t_frame

    // two addressed words, one strobe
    task automatic t_addr();
        mode <= 1'b1;
        expm = F1;
        expm[3] = 5'h09;
        expm[7] = 5'h1F;
        xp_ctrl_model_inst.xfer({72'h0, 8'h4B}, 8, 1'b1);
        chk_word({31'h0, sdout}, 32'h0);
        xp_ctrl_model_inst.xfer({72'h0, 8'hFF}, 8, 1'b1);
        // new pending and addressed mode flags, no transfer open
        rd_chk(XP_REG_STATUS, 32'h00000003, XP_RESP_OKAY);
        rd_chk(XP_REG_PEND_HI, {24'h0, expm[7], expm[6][4:2]}, XP_RESP_OKAY);
        xp_ctrl_model_inst.cfg_pulse();
        chk_map(expm);
        mode <= 1'b0;
    endtask : t_addr

    // double length stream as for a two-device chain
    task automatic t_chain();
        xp_ctrl_model_inst.xfer({F2, F1}, 80, 1'b1);
        chk_word(xp_ctrl_model_inst.cap[71:40], F1[31:0]);
        chk_word({24'h0, xp_ctrl_model_inst.cap[79:72]}, {24'h0, F1[39:32]});
        xp_ctrl_model_inst.cfg_pulse();
        chk_map(F2);
        rd_chk(XP_REG_ACT_LO, F2[31:0], XP_RESP_OKAY);
    endtask : t_chain

    // level overrides by pin and by register
    task automatic t_override();
        rst <= 1'b1;
        repeat (4) @(posedge aclk);
        chk_map(M_RST);
        bcast <= 1'b1;
        repeat (4) @(posedge aclk);
        chk_map(M_RST);
        rst <= 1'b0;
        repeat (4) @(posedge aclk);
        chk_map(M_BC);
        bcast <= 1'b0;
        repeat (4) @(posedge aclk);
        chk_map(M_BC);
        xp_ctrl_model_inst.cfg_pulse();
        chk_map(M_BC);
        wr_chk(XP_REG_CTRL, 32'h00000001, XP_RESP_OKAY);
        chk_map(M_RST);
        wr_chk(XP_REG_CTRL, 32'h00000002, XP_RESP_OKAY);
        chk_map(M_BC);
        wr_chk(XP_REG_CTRL, 32'h00000000, XP_RESP_OKAY);
        rd_chk(XP_REG_CTRL, 32'h00000000, XP_RESP_OKAY);
    endtask : t_override

    // main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_frame();
        t_addr();
        t_chain();
        t_override();
        final_report();
    end

    // watchdog, several times the expected run length
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
endmodule : xp_serial_port_tb
